//--- spj_justifier.sv
// Slip buffer with STS-1 pointer justification towards the read side
`default_nettype none

module spj_justifier #(
   parameter int DEPTH     = 16,
   parameter int FILL_LOW  = 4,
   parameter int FILL_HIGH = 12
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   // Write side pins
   input  wire logic                      write_side_clock,
   input  wire spj_pkg::spj_in_s          wr_byte,
   // Read side pins
   input  wire logic                      read_side_clock,
   // Outgoing stream
   input  wire logic                      out_ready,
   output logic                           out_valid,
   output spj_pkg::spj_out_s              out_byte,
   // Status
   output logic [9:0]                     cur_pointer,
   output logic [$clog2(DEPTH):0]         fill_level
);
   import spj_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int FW = AW + 1;

   //==============================================================
   // Elaboration checks
   if (DEPTH < 4 || (1 << AW) != DEPTH)
      $error("DEPTH must be a power of two of at least 4");
   if (FILL_LOW < 1 || FILL_HIGH <= FILL_LOW || FILL_HIGH >= DEPTH)
      $error("Need 1 <= FILL_LOW < FILL_HIGH < DEPTH");

   //==============================================================
   // Helpers
   // (R10) (R17) step with wrap
   // Step the pointer one place with wrap over the valid range
   function automatic logic [9:0] step_ptr(input logic [9:0] p, input spj_adj_e a);
      logic [9:0] r;
      r = p;
      if (a == SPJ_INC)
         r = (p >= PTR_MAX) ? 10'h000 : p + 10'h001;
      else if (a == SPJ_DEC)
         r = (p == 10'h000) ? PTR_MAX : p - 10'h001;
      return r;
   endfunction : step_ptr

   // (R9) (R14) ten-bit pointer field
   // Build the H1/H2 word with the announcing bits inverted
   function automatic logic [15:0] ptr_word(input logic [9:0] p, input spj_adj_e a);
      logic [9:0] v;
      v = p;
      if (a == SPJ_INC)
         v = p ^ I_MASK;
      else if (a == SPJ_DEC)
         v = p ^ D_MASK;
      return {NDF_NORMAL, SS_BITS, v};
   endfunction : ptr_word

   //==============================================================
   // Pin synchronisers, three stages each
   logic [2:0]   wclk_s;
   logic [2:0]   rclk_s;
   spj_in_s      wdat_s1;
   spj_in_s      wdat_s2;
   spj_in_s      wdat_s3;
   logic         wclk_lvl;
   logic         rclk_lvl;
   logic         wr_edge;
   logic         rd_edge;

   // Shift pin samples in, clock stages cleared so no unknown edge follows reset
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wclk_s <= '0;
         rclk_s <= '0;
      end
      else
      begin
         wclk_s <= {wclk_s[1:0], write_side_clock};
         rclk_s <= {rclk_s[1:0], read_side_clock};
      end
      wdat_s1 <= wr_byte;
      wdat_s2 <= wdat_s1;
      wdat_s3 <= wdat_s2;
   end

   // Settled levels once stages two and three agree
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wclk_lvl <= 1'b0;
         rclk_lvl <= 1'b0;
      end
      else
      begin
         if (wclk_s[1] == wclk_s[2])
            wclk_lvl <= wclk_s[2];
         if (rclk_s[1] == rclk_s[2])
            rclk_lvl <= rclk_s[2];
      end
   end

   assign wr_edge = (wclk_s[1] == wclk_s[2]) && wclk_s[2] && !wclk_lvl;
   assign rd_edge = (rclk_s[1] == rclk_s[2]) && rclk_s[2] && !rclk_lvl;

   //==============================================================
   // Slip buffer
   spj_in_s      mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [FW-1:0] fill;
   logic         push_w;
   logic         pop_r;
   logic         sb_empty;

   assign sb_empty = (fill == '0);
   // (R1) write on write-side edge
   assign push_w   = wr_edge && (fill != FW'(DEPTH));

   // Store incoming bytes
   always_ff @(posedge clk)
   begin
      if (push_w)
         mem[wptr] <= wdat_s3;
   end

   // Pointers and fill count
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wptr <= '0;
         rptr <= '0;
         fill <= '0;
      end
      else
      begin
         if (push_w)
            wptr <= wptr + AW'(1);
         if (pop_r)
            rptr <= rptr + AW'(1);
         fill <= fill + FW'(push_w) - FW'(pop_r);
      end
   end

   //==============================================================
   // Read side frame position
   logic [3:0]   row;
   logic [6:0]   col;
   logic         rd_pend;
   logic         fire;
   logic         bf_ready;
   logic         at_h1;
   logic         at_h2;
   logic         at_h3;
   logic         at_first;

   assign fire     = rd_pend && bf_ready;
   assign at_h1    = (row == PTR_ROW) && (col == H1_COL);
   assign at_h2    = (row == PTR_ROW) && (col == H2_COL);
   assign at_h3    = (row == PTR_ROW) && (col == H3_COL);
   // (R15) envelope slot zero
   assign at_first = (row == PTR_ROW) && (col == TOH_COLS);

   // Hold a read edge until the output buffer takes the byte
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rd_pend <= 1'b0;
      else if (rd_edge)
         rd_pend <= 1'b1;
      else if (fire)
         rd_pend <= 1'b0;
   end

   // Byte slot counter
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         row <= '0;
         col <= '0;
      end
      else if (fire)
      begin
         if (col == COLS - 7'h1)
         begin
            col <= '0;
            row <= (row == ROWS - 4'h1) ? 4'h0 : row + 4'h1;
         end
         else
            col <= col + 7'h1;
      end
   end

   //==============================================================
   // Pointer and adjustment decision
   spj_adj_e     adj_cur;
   spj_adj_e     next_adj;
   logic [9:0]   ptr;
   logic [9:0]   next_ptr;
   logic [15:0]  word_q;

   // (R2) (R3) (R7) thresholds pick kind
   // (R16) one adjustment per frame, by threshold
   always_comb
   begin
      next_adj = SPJ_NONE;
      if (adj_cur == SPJ_NONE)
      begin
         if (fill < FW'(FILL_LOW))
            next_adj = SPJ_INC;
         else if (fill > FW'(FILL_HIGH))
            next_adj = SPJ_DEC;
      end
   end

   // (R6) (R10) (R11) one step next frame
   assign next_ptr = step_ptr(ptr, adj_cur);

   // Update pointer and decision at each H1 slot
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ptr     <= PTR_RESET;
         adj_cur <= SPJ_NONE;
         word_q  <= '0;
      end
      else if (fire && at_h1)
      begin
         ptr     <= next_ptr;
         adj_cur <= next_adj;
         word_q  <= ptr_word(next_ptr, next_adj);
      end
   end

   //==============================================================
   // Outgoing byte generation
   spj_out_s     gen;
   logic [15:0]  h1_word;

   assign h1_word = ptr_word(next_ptr, next_adj);

   // Fill the current slot and decide whether to pop
   always_comb
   begin
      gen        = '0;
      pop_r      = 1'b0;
      gen.fstart = (row == 4'h0) && (col == 7'h0);
      if (at_h1)
      begin
         // (R5) (R9) I or D bits inverted
         gen.h1   = 1'b1;
         gen.data = h1_word[15:8];
      end
      else if (at_h2)
      begin
         gen.h2   = 1'b1;
         gen.data = word_q[7:0];
      end
      else if (at_h3)
      begin
         gen.h3 = 1'b1;
         // (R8) payload byte carried in H3
         if (adj_cur == SPJ_DEC && !sb_empty)
         begin
            pop_r    = fire;
            gen.spe  = 1'b1;
            gen.j1   = mem[rptr].j1;
            gen.data = mem[rptr].data;
         end
      end
      else if (col >= TOH_COLS)
      begin
         // (R3) (R4) (R11) dummy byte after H3
         if ((at_first && adj_cur == SPJ_INC) || sb_empty)
            gen.stuff = 1'b1;
         else
         begin
            pop_r    = fire;
            gen.spe  = 1'b1;
            gen.j1   = mem[rptr].j1;
            gen.data = mem[rptr].data;
         end
      end
   end

   //==============================================================
   // Two-entry output buffer
   spj_out_s     b1;
   logic [1:0]   bcnt;
   logic         bpop;
   logic [1:0]   next_bcnt;

   assign bf_ready  = (bcnt != 2'd2);
   assign bpop      = out_valid && out_ready;
   assign next_bcnt = bcnt + 2'(fire) - 2'(bpop);

   // Entry count and valid flag
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         bcnt      <= '0;
         out_valid <= 1'b0;
      end
      else
      begin
         bcnt      <= next_bcnt;
         out_valid <= (next_bcnt != 2'd0);
      end
   end

   // Head and second entry data
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         out_byte <= '0;
         b1       <= '0;
      end
      else
      begin
         if (bpop)
         begin
            if (bcnt == 2'd2)
               out_byte <= b1;
            else if (fire)
               out_byte <= gen;
         end
         else if (fire && bcnt == 2'd0)
            out_byte <= gen;
         if (fire && ((bcnt == 2'd1 && !bpop) || (bcnt == 2'd2 && bpop)))
            b1 <= gen;
      end
   end

   // Status registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cur_pointer <= PTR_RESET;
         fill_level  <= '0;
      end
      else
      begin
         cur_pointer <= ptr;
         fill_level  <= fill;
      end
   end

   //==============================================================
   // Checks
   sequence s_h1;
      fire && at_h1;
   endsequence

   property p_wr_fill;
      @(posedge clk) disable iff (sys_rst) push_w && !pop_r |=> fill == $past(fill) + FW'(1);
   endproperty
   a_wr_fill: assert property (p_wr_fill) else $error("write edge did not raise fill"); // (R1)

   property p_steady;
      @(posedge clk) disable iff (sys_rst)
         s_h1 ##0 (fill >= FW'(FILL_LOW) && fill <= FW'(FILL_HIGH)) |=> adj_cur == SPJ_NONE;
   endproperty
   a_steady: assert property (p_steady) else $error("adjustment with fill in band"); // (R2)

   property p_pos_stuff;
      @(posedge clk) disable iff (sys_rst)
         fire && at_first && adj_cur == SPJ_INC |-> gen.stuff && !pop_r;
   endproperty
   a_pos_stuff: assert property (p_pos_stuff) else $error("no dummy after H3"); // (R4)

   property p_ibits;
      @(posedge clk) disable iff (sys_rst)
         s_h1 ##0 next_adj == SPJ_INC |-> gen.data == 8'({NDF_NORMAL, SS_BITS, next_ptr ^ I_MASK} >> 8);
   endproperty
   a_ibits: assert property (p_ibits) else $error("I bits not inverted"); // (R5)

   property p_inc_next;
      @(posedge clk) disable iff (sys_rst)
         s_h1 ##0 adj_cur == SPJ_INC |=> ptr == step_ptr($past(ptr), SPJ_INC);
   endproperty
   a_inc_next: assert property (p_inc_next) else $error("pointer not raised after stuff"); // (R6)

   property p_neg_stuff;
      @(posedge clk) disable iff (sys_rst)
         fire && at_h3 && adj_cur == SPJ_DEC && !sb_empty |-> pop_r && gen.spe;
   endproperty
   a_neg_stuff: assert property (p_neg_stuff) else $error("H3 not filled on negative stuff"); // (R8)

   property p_dbits;
      @(posedge clk) disable iff (sys_rst)
         s_h1 ##0 next_adj == SPJ_DEC |-> gen.data == 8'({NDF_NORMAL, SS_BITS, next_ptr ^ D_MASK} >> 8);
   endproperty
   a_dbits: assert property (p_dbits) else $error("D bits not inverted"); // (R9)

   property p_one_step;
      @(posedge clk) disable iff (sys_rst)
         ptr != $past(ptr) |-> ptr == step_ptr($past(ptr), SPJ_INC) || ptr == step_ptr($past(ptr), SPJ_DEC);
   endproperty
   a_one_step: assert property (p_one_step) else $error("pointer moved more than one"); // (R11)

   property p_valid_ptr;
      @(posedge clk) disable iff (sys_rst) ptr < PTR_INVALID;
   endproperty
   a_valid_ptr: assert property (p_valid_ptr) else $error("pointer left valid range"); // (R14)

   property p_spacing;
      @(posedge clk) disable iff (sys_rst) s_h1 ##0 adj_cur != SPJ_NONE |-> next_adj == SPJ_NONE;
   endproperty
   a_spacing: assert property (p_spacing) else $error("adjustments in adjacent frames"); // (R16)

endmodule : spj_justifier

`default_nettype wire

//--- spj_pkg.sv
// Constants and types for the STS-1 pointer justification block
//==============================================================
// Functional notes
// (R1) Incoming STS-1 bytes enter the slip buffer on a write-side clock edge and leave on a read-side clock edge.
// (R2) With equal write and read rates the fill stays between thresholds, so no adjustment occurs and the offset holds.
// (R3) When the buffer runs low because reads outpace writes, one dummy byte without information is inserted.
// (R4) In a positive-stuff frame the dummy byte sits directly after H3, growing the offset from H3 by one byte.
// (R5) In a positive-stuff frame the I bits of the 16-bit H1/H2 pointer word are sent inverted.
// (R6) In the frame after a positive stuff the I bits are normal again and the pointer is one higher.
// (R7) When the buffer runs high because writes outpace reads, one payload byte is taken out of the normal slots.
// (R8) In a negative-stuff frame that payload byte is sent in the H3 slot, shrinking the H3-to-J1 distance by one.
// (R9) In a negative-stuff frame the D bits of the H1/H2 pointer word are sent inverted.
// (R10) In the frame after a negative stuff the D bits are normal again and the pointer is one lower.
// (R11) Every adjustment moves the payload envelope by exactly one byte, up or down.
// (R12) The mapper pulses its clock only while a DS3 payload bit is on its data output, never for overhead bits.
// (R13) The mapper clock has the STS-1 bit period yet delivers about 44,736,000 pulses a second, one per DS3 bit.
// (R14) The pointer is the low ten bits of the H1/H2 word with H1 as upper byte; values above 0x30E are invalid.
// (R15) Pointer zero puts J1 in the envelope slot directly after H3.
// (R16) At most one adjustment per frame, started only when the fill crosses a low or high threshold.
// (R17) The pointer wraps modulo the 783 valid positions when stepped across the range boundary.
`default_nettype none

package spj_pkg;

   //==============================================================
   // Frame geometry
   localparam logic [3:0]  ROWS        = 4'h9;
   localparam logic [6:0]  COLS        = 7'h5A;
   localparam logic [6:0]  TOH_COLS    = 7'h3;
   localparam logic [3:0]  PTR_ROW     = 4'h3;
   localparam logic [6:0]  H1_COL      = 7'h0;
   localparam logic [6:0]  H2_COL      = 7'h1;
   localparam logic [6:0]  H3_COL      = 7'h2;

   //==============================================================
   // Pointer word layout
   localparam logic [9:0]  PTR_MAX     = 10'h30E;  // Last valid position
   localparam logic [9:0]  PTR_INVALID = 10'h30F;  // This and above are invalid
   localparam logic [3:0]  NDF_NORMAL  = 4'b0110;
   localparam logic [1:0]  SS_BITS     = 2'b00;
   localparam logic [9:0]  I_MASK      = 10'h2AA;
   localparam logic [9:0]  D_MASK      = 10'h155;
   localparam logic [9:0]  PTR_RESET   = 10'h000;

   //==============================================================
   // Timing of the link clock seen in the bench
   localparam int          CLK_NS      = 8;
   localparam int          LINK_NS     = 64;
   localparam int          LINK_CYC    = LINK_NS / CLK_NS;

   //==============================================================
   // Adjustment kinds
   typedef enum logic [1:0] {SPJ_NONE, SPJ_INC, SPJ_DEC} spj_adj_e;

   // Byte as captured from the write side
   typedef struct packed {
      logic       j1;
      logic [7:0] data;
   } spj_in_s;

   // Byte leaving towards the receiving terminal
   typedef struct packed {
      logic       fstart;
      logic       h1;
      logic       h2;
      logic       h3;
      logic       spe;
      logic       j1;
      logic       stuff;
      logic [7:0] data;
   } spj_out_s;

endpackage : spj_pkg

`default_nettype wire

//--- spj_far_model.sv
// Far-side model: STS-1 byte source, read-slot clock and stalling receiver
`default_nettype none

module spj_far_model (
   // Clock
   input  wire logic             clk,
   // Rate controls, period in clk cycles
   input  wire logic             wr_run,
   input  wire logic             rd_run,
   input  wire logic [3:0]       wr_per,
   input  wire logic [3:0]       rd_per,
   // Link side
   output logic                  write_side_clock,
   output spj_pkg::spj_in_s      wr_byte,
   output logic                  read_side_clock,
   output logic                  out_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   import spj_pkg::*;

   logic [3:0] wcnt;
   logic [3:0] rcnt;
   logic [3:0] scnt;
   logic [6:0] wcol;

   //==============================================================
   // Link clocks
   // Clocks stand low while stopped; byte moves at start of low half
   initial
   begin
      wcnt = 4'h0;
      rcnt = 4'h0;
      scnt = 4'h0;
      wcol = 7'h00;
      write_side_clock = 1'b0;
      read_side_clock = 1'b0;
      wr_byte = '0;
      out_ready = 1'b1;
      forever
      begin
         @(posedge clk);
         #1;
         wcnt = (wr_run && wcnt + 4'h1 < wr_per) ? wcnt + 4'h1 : 4'h0;
         rcnt = (rd_run && rcnt + 4'h1 < rd_per) ? rcnt + 4'h1 : 4'h0;
         scnt = scnt + 4'h1;
         if (wr_run && wcnt == 4'h0)
         begin
            wcol = (wcol == COLS - 7'h01) ? 7'h00 : wcol + 7'h01;
            if (wcol >= TOH_COLS)
            begin
               wr_byte.data = wr_byte.data + 8'h01;
               wr_byte.j1 = (wr_byte.data == 8'h00);
            end
         end
         write_side_clock = wr_run && (wcol >= TOH_COLS) && (wcnt >= (wr_per >> 1));
         read_side_clock = rd_run && (rcnt >= (rd_per >> 1));
         // Receiver stalls four cycles in sixteen
         out_ready = (scnt[3:2] != 2'b11);
      end
   end

endmodule : spj_far_model

`default_nettype wire

//--- tb_spj_justifier.sv
// Self-checking bench for the STS-1 pointer justification block
`default_nettype none

module tb_spj_justifier;
   timeunit 1ns;
   timeprecision 100ps;
   import spj_pkg::*;

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", nm, (e), (g)); end end

   localparam int LOW  = 4;
   localparam int HIGH = 12;

   logic            clk;
   logic            sys_rst;
   logic            write_side_clock;
   logic            read_side_clock;
   logic            out_ready;
   logic            out_valid;
   logic            wr_run;
   logic            rd_run;
   logic [3:0]      wr_per;
   logic [3:0]      rd_per;
   spj_in_s         wr_byte;
   spj_out_s        out_byte;
   spj_out_s        hold_b;
   logic [9:0]      cur_pointer;
   logic [4:0]      fill_level;
   logic [9:0]      ptr_exp;
   logic [7:0]      hi;
   logic [7:0]      last;
   logic [15:0]     w;
   logic            hold_v;
   logic            seq_on;
   logic            seq_ok;
   spj_adj_e        kind;
   spj_adj_e        adj_last;
   int              idx;
   int              n_frames;
   int              n_inc;
   int              n_dec;
   int              n_mismatch;
   int              n_checks;

   //==============================================================
   // Clock, design and far side
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   spj_justifier #(.DEPTH(16), .FILL_LOW(LOW), .FILL_HIGH(HIGH)) dut (
      .clk(clk), .sys_rst(sys_rst), .write_side_clock(write_side_clock), .wr_byte(wr_byte),
      .read_side_clock(read_side_clock), .out_ready(out_ready), .out_valid(out_valid),
      .out_byte(out_byte), .cur_pointer(cur_pointer), .fill_level(fill_level));

   spj_far_model far (
      .clk(clk), .wr_run(wr_run), .rd_run(rd_run), .wr_per(wr_per), .rd_per(rd_per),
      .write_side_clock(write_side_clock), .wr_byte(wr_byte),
      .read_side_clock(read_side_clock), .out_ready(out_ready));

   //==============================================================
   // Stream monitor: held bytes, pointer word, stuff positions
   always @(posedge clk)
   begin
      if (hold_v)
      begin
         `CHK("held_valid", 1'b1, out_valid)
         `CHK("held_byte", hold_b, out_byte)
      end
      hold_v = out_valid && !out_ready;
      hold_b = out_byte;
      if (out_valid && out_ready)
      begin
         idx = out_byte.fstart ? 0 : (idx < 1000 ? idx + 1 : idx);
         if (seq_on && out_byte.spe && !out_byte.stuff)
         begin
            if (seq_ok) `CHK("payload_order", last + 8'h01, out_byte.data)
            last = out_byte.data;
            seq_ok = 1'b1;
         end
         if (idx == 270)
            hi = out_byte.data;
         if (idx == 271)
         begin
            if (adj_last == SPJ_INC) ptr_exp = (ptr_exp == PTR_MAX) ? 10'h000 : ptr_exp + 10'h001;
            if (adj_last == SPJ_DEC) ptr_exp = (ptr_exp == 10'h000) ? PTR_MAX : ptr_exp - 10'h001;
            w = {hi, out_byte.data};
            kind = SPJ_NONE;
            if (adj_last == SPJ_NONE && w[9:0] == (ptr_exp ^ I_MASK)) kind = SPJ_INC;
            if (adj_last == SPJ_NONE && w[9:0] == (ptr_exp ^ D_MASK)) kind = SPJ_DEC;
            `CHK("ptr_word", {NDF_NORMAL, SS_BITS, ptr_exp ^ (kind == SPJ_INC ? I_MASK :
               (kind == SPJ_DEC ? D_MASK : 10'h000))}, w)
            n_inc += (kind == SPJ_INC);
            n_dec += (kind == SPJ_DEC);
            adj_last = kind;
         end
         if (idx == 272)
         begin
            `CHK("h3_payload", kind == SPJ_DEC, out_byte.spe)
            `CHK("cur_pointer", ptr_exp, cur_pointer)
            n_frames++;
         end
         if (idx == 273 && kind == SPJ_INC) `CHK("stuff_after_h3", 1'b1, out_byte.stuff)
      end
   end

   //==============================================================
   // Scenarios
   task automatic t_reset;
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      `CHK("rst_valid", 1'b0, out_valid)
      `CHK("rst_ptr", PTR_RESET, cur_pointer)
      `CHK("rst_fill", 5'd0, fill_level)
   endtask : t_reset

   task automatic t_equal;
      wr_run = 1'b1;
      wait (fill_level == 5'h06);
      @(posedge clk);
      #1 rd_run = 1'b1;
      seq_on = 1'b1;
      wait (n_frames >= 2);
      seq_on = 1'b0;
      `CHK("equal_adj", 0, n_inc + n_dec)
      `CHK("equal_fill", 1'b1, fill_level >= 5'(LOW) && fill_level <= 5'(HIGH))
   endtask : t_equal

   task automatic t_fast;
      int f;
      @(posedge clk);
      #1 wr_per = 4'd7;
      wait (n_dec >= 1);
      f = n_frames;
      wait (n_frames >= f + 2);
      `CHK("dec_wrap", PTR_MAX, cur_pointer)
   endtask : t_fast

   task automatic t_slow;
      int         f;
      logic [9:0] p0;
      @(posedge clk);
      #1 wr_per = 4'd9;
      wait (n_inc >= 1);
      f  = n_frames;
      p0 = ptr_exp;
      wait (n_frames >= f + 2);
      `CHK("inc_step", (p0 == PTR_MAX) ? 10'h000 : p0 + 10'h001, cur_pointer)
   endtask : t_slow

   //==============================================================
   // Verdict and watchdog
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   initial
   begin
      #750000;
      n_mismatch++;
      summarize();
   end

   initial
   begin
      {sys_rst, wr_run, rd_run, hold_v, seq_on, seq_ok} = 6'b100000;
      {wr_per, rd_per} = {4'd8, 4'd8};
      {ptr_exp, hi, last, w, hold_b} = '0;
      kind       = SPJ_NONE;
      adj_last   = SPJ_NONE;
      idx        = 1000;
      n_frames   = 0;
      n_inc      = 0;
      n_dec      = 0;
      n_mismatch = 0;
      n_checks   = 0;
      t_reset();
      t_equal();
      t_fast();
      t_slow();
      summarize();
   end

endmodule : tb_spj_justifier

`default_nettype wire
